// [shared/bcr_defs.svh]
// Offsets, bit positions, reset values and timing for the bridge
// control and retry register bank.
// Assumes inclusion by bare name from package and design files.
`ifndef BCR_DEFS_SVH
`define BCR_DEFS_SVH

// ------------------------------------------------------------
// Register offsets (byte offsets in configuration space)
// ------------------------------------------------------------
`define BCR_OFF_BRIDGE_CONTROL  8'h3e
`define BCR_OFF_SUBSYS_VENDOR   8'h40
`define BCR_OFF_SUBSYS          8'h42
`define BCR_OFF_LEGACY_BASE     8'h44
`define BCR_OFF_RETRY_CONTROL   8'h90

// ------------------------------------------------------------
// Bridge control fields
// ------------------------------------------------------------
`define BCR_BC_PREF1            9
`define BCR_BC_PREF0            8
`define BCR_BC_CB_RESET         6
`define BCR_BC_MA_MODE          5
`define BCR_BC_ISA_EN           2
`define BCR_BC_SERR_EN          1
`define BCR_BC_PERR_EN          0
`define BCR_BC_RESET            16'h0340

// ------------------------------------------------------------
// Legacy port base and retry control fields
// ------------------------------------------------------------
`define BCR_LB_BASE_LSB         12
`define BCR_LB_IO_SPACE         1'h1
`define BCR_LEGACY_FIXED        32'h000003e0
`define BCR_RC_PCI_EN           7
`define BCR_RC_CB_EN            6
`define BCR_RC_RESET            8'h00

// ------------------------------------------------------------
// Retry timing and address checks
// ------------------------------------------------------------
`define BCR_RTY_CNT_W           16
`define BCR_RTY_LIMIT           1024
`define BCR_ISA_LOW_SPAN_MSB    31
`define BCR_ISA_LOW_SPAN_LSB    16

`endif

// [shared/bcr_pkg.sv]
// Types for the bridge control and retry register bank.
// Assumes bcr_defs.svh is on the include path.
`include "bcr_defs.svh"

package bcr_pkg;

    // ------------------------------------------------------------
    // Retry timer state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [`BCR_RTY_CNT_W-1:0] cnt;
        logic                      fired;
        logic                      expire;
    } bcr_timer_t;

    // ------------------------------------------------------------
    // Register bank state
    // ------------------------------------------------------------
    typedef struct packed {
        logic        cb_reset;
        logic        ma_mode;
        logic        isa_en;
        logic        serr_fwd_en;
        logic        perr_resp_en;
        logic [19:0] legacy_base;
        logic        pci_rty_en;
        logic        cb_rty_en;
        logic [3:0]  rty_expired;
        logic [31:0] rd_data;
        logic        serr_meta;
        logic        serr_sync;
        logic        perr_meta;
        logic        perr_sync;
        logic [1:0]  prefetch;
        logic        io_fwd;
        logic        index_hit;
        logic        data_hit;
        logic        bad_hit;
        logic        ma_ones;
        logic        ma_drop;
        logic        ma_tabort;
        logic        pci_serr;
        logic        perr_report;
    } bcr_state_t;

endpackage

// [core/bcr_retry_timer.sv]
// One retry timeout counter with an expiry pulse.
// Assumes active_in comes from logic on clk_sys_in.
`include "bcr_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module bcr_retry_timer #(
    parameter int unsigned LIMIT = `BCR_RTY_LIMIT
) (
    input  wire logic clk_sys_in,
    input  wire logic reset_n_in,
    input  wire logic enable_in,
    input  wire logic active_in,
    output logic      expire_out
);

    localparam logic [`BCR_RTY_CNT_W-1:0] LAST =
        `BCR_RTY_CNT_W'(LIMIT - 1);

    bcr_pkg::bcr_timer_t s_r;
    bcr_pkg::bcr_timer_t s_nxt;

    // ------------------------------------------------------------
    // Counting
    // ------------------------------------------------------------
    always_comb begin
        s_nxt        = s_r;
        s_nxt.expire = 1'b0;
        if (!enable_in || !active_in) begin
            s_nxt.cnt   = '0;
            s_nxt.fired = 1'b0;
        end else if (!s_r.fired) begin
            if (s_r.cnt == LAST) begin
                s_nxt.expire = 1'b1;
                s_nxt.fired  = 1'b1;
            end else begin
                s_nxt.cnt = s_r.cnt + 1'b1;
            end
        end
    end

    // Stays fired until the retried transfer ends or the timer is disabled, one pulse each
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign expire_out = s_r.expire;

endmodule
`default_nettype wire

// [core/bcr_regs.sv]
// Bridge control, subsystem codes, legacy port base and retry
// control registers of the card bridge, with the logic they steer.
// Assumes a single-cycle register port on clk_sys_in; card-side
// pins arrive asynchronously and are synchronised here.
//
// What this block does
// - Both window prefetch enables fixed at one
// - Card reset bit drives card reset pin
// - Mode zero: reads all-ones, writes dropped
// - Mode one: target abort while origin open
// - Mode one posted write: error if enabled
// - ISA bit blocks upper 768 bytes forward
// - Blocking one direction only; resets zero
// - Forward card error only when enabled
// - Parity check and report only when enabled
// - Reserved bridge control bits read zero
// - Subsystem vendor code fixed, writes ignored
// - Subsystem code fixed, read only
// - Legacy index/data pair, relocatable to any 4 KB boundary
// - Index at base, data at base+1
// - Legacy base bit0 one, bit1 zero
// - PCI retry counter runs only enabled
// - Card retry counter runs only enabled
// - Four sticky expiry flags, write-one clears
// - Retry control bits 5:4 read zero
// - Prefetch windows need memory enable bit
//
// Our own choice: the address-and-strobe port.
`include "bcr_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module bcr_regs #(
    parameter logic [15:0] SUBSYS_VENDOR = 16'h5a3c,
    parameter logic [15:0] SUBSYS_CODE   = 16'h3c5a,
    parameter int unsigned RETRY_LIMIT   = `BCR_RTY_LIMIT
) (
    input  wire logic        clk_sys_in,
    input  wire logic        reset_n_in,
    // Register port
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [31:0] reg_rdata_out,
    // Command register bits from the configuration header
    input  wire logic        cmd_mem_en_in,
    input  wire logic        cmd_serr_en_in,
    // Memory window prefetch
    output logic      [1:0]  mem_prefetch_out,
    // Card reset pin, active low
    output logic             cb_reset_n_out,
    // Master abort report from the forwarding path
    input  wire logic        ma_event_in,
    input  wire logic        ma_read_in,
    input  wire logic        ma_posted_in,
    input  wire logic        ma_origin_open_in,
    output logic             ma_read_ones_out,
    output logic             ma_write_drop_out,
    output logic             ma_target_abort_out,
    // IO forwarding check
    input  wire logic [31:0] io_addr_in,
    input  wire logic        io_valid_in,
    input  wire logic        io_window_hit_in,
    input  wire logic        io_to_card_in,
    output logic             io_forward_out,
    // Legacy index/data port decode
    output logic             legacy_index_hit_out,
    output logic             legacy_data_hit_out,
    output logic             legacy_bad_hit_out,
    // Card-side error pins, active low
    input  wire logic        cb_serr_n_in,
    input  wire logic        cb_perr_n_in,
    output logic             pci_serr_out,
    output logic             perr_report_out,
    // Retried transactions: 3 card target, 2 card master,
    // 1 PCI target, 0 PCI master
    input  wire logic [3:0]  retry_active_in
);

    bcr_pkg::bcr_state_t s_r;
    bcr_pkg::bcr_state_t s_nxt;

    logic [3:0]  rty_set;
    logic [15:0] bc_view;
    logic [31:0] lb_view;
    logic [7:0]  rc_view;
    logic        wr_bc;
    logic        wr_lb;
    logic        wr_rc;
    logic        isa_block;
    logic        low_span;
    logic        upper_part;
    logic        base_match;
    logic        fixed_match;
    logic [1:0]  pair_off;

    // ------------------------------------------------------------
    // Retry timers, one per retry role
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_rty
            logic en_w;
            assign en_w = (gi >= 2) ? s_r.cb_rty_en : s_r.pci_rty_en;
            bcr_retry_timer #(
                .LIMIT (RETRY_LIMIT)
            ) u_timer (
                .clk_sys_in (clk_sys_in),
                .reset_n_in (reset_n_in),
                .enable_in  (en_w),
                .active_in  (retry_active_in[gi]),
                .expire_out (rty_set[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Register read views
    // ------------------------------------------------------------
    always_comb begin
        bc_view                       = 16'h0000;
        bc_view[`BCR_BC_PREF1]        = 1'b1;
        bc_view[`BCR_BC_PREF0]        = 1'b1;
        bc_view[`BCR_BC_CB_RESET]     = s_r.cb_reset;
        bc_view[`BCR_BC_MA_MODE]      = s_r.ma_mode;
        bc_view[`BCR_BC_ISA_EN]       = s_r.isa_en;
        bc_view[`BCR_BC_SERR_EN]      = s_r.serr_fwd_en;
        bc_view[`BCR_BC_PERR_EN]      = s_r.perr_resp_en;
    end

    assign lb_view = {s_r.legacy_base, 11'h000, `BCR_LB_IO_SPACE};

    assign rc_view = {s_r.pci_rty_en, s_r.cb_rty_en, 2'h0,
                      s_r.rty_expired};

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    always_comb begin
        wr_bc = 1'b0;
        wr_lb = 1'b0;
        wr_rc = 1'b0;
        if (!reg_wr_in) begin
            wr_bc = 1'b0;
        end else if (reg_addr_in == `BCR_OFF_BRIDGE_CONTROL) begin
            wr_bc = 1'b1;
        end else if (reg_addr_in == `BCR_OFF_LEGACY_BASE) begin
            wr_lb = 1'b1;
        end else if (reg_addr_in == `BCR_OFF_RETRY_CONTROL) begin
            wr_rc = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // IO address checks
    // ------------------------------------------------------------
    // first 64 KB only
    assign low_span =
        io_addr_in[`BCR_ISA_LOW_SPAN_MSB:`BCR_ISA_LOW_SPAN_LSB] == '0;
    // Offsets 100h..3FFh of each 1 KB block
    assign upper_part = io_addr_in[9:8] != 2'h0;
    assign isa_block = s_r.isa_en & io_to_card_in & low_span &
                       upper_part;

    assign base_match =
        io_addr_in[31:`BCR_LB_BASE_LSB] == s_r.legacy_base &&
        io_addr_in[`BCR_LB_BASE_LSB-1:2] == '0;
    assign fixed_match = io_addr_in[31:2] == 30'(`BCR_LEGACY_FIXED >> 2);
    assign pair_off    = io_addr_in[1:0];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;

        // Pin synchronisers
        s_nxt.serr_meta = cb_serr_n_in;
        s_nxt.serr_sync = s_r.serr_meta;
        s_nxt.perr_meta = cb_perr_n_in;
        s_nxt.perr_sync = s_r.perr_meta;

        if (wr_bc) begin
            s_nxt.cb_reset     = reg_wdata_in[`BCR_BC_CB_RESET];
            s_nxt.ma_mode      = reg_wdata_in[`BCR_BC_MA_MODE];
            s_nxt.isa_en       = reg_wdata_in[`BCR_BC_ISA_EN];
            s_nxt.serr_fwd_en  = reg_wdata_in[`BCR_BC_SERR_EN];
            s_nxt.perr_resp_en = reg_wdata_in[`BCR_BC_PERR_EN];
        end
        if (wr_lb) begin
            s_nxt.legacy_base = reg_wdata_in[31:`BCR_LB_BASE_LSB];
        end
        if (wr_rc) begin
            s_nxt.pci_rty_en = reg_wdata_in[`BCR_RC_PCI_EN];
            s_nxt.cb_rty_en  = reg_wdata_in[`BCR_RC_CB_EN];
        end

        s_nxt.rty_expired =
            (s_r.rty_expired & ~(wr_rc ? reg_wdata_in[3:0] : 4'h0)) |
            rty_set;

        // Read data stands one cycle only
        s_nxt.rd_data = 32'h00000000;
        if (!reg_rd_in) begin
            s_nxt.rd_data = 32'h00000000;
        end else if (reg_addr_in == `BCR_OFF_BRIDGE_CONTROL) begin
            s_nxt.rd_data = {16'h0000, bc_view};
        end else if (reg_addr_in == `BCR_OFF_SUBSYS_VENDOR) begin
            s_nxt.rd_data = {16'h0000, SUBSYS_VENDOR};
        end else if (reg_addr_in == `BCR_OFF_SUBSYS) begin
            s_nxt.rd_data = {16'h0000, SUBSYS_CODE};
        end else if (reg_addr_in == `BCR_OFF_LEGACY_BASE) begin
            s_nxt.rd_data = lb_view;
        end else if (reg_addr_in == `BCR_OFF_RETRY_CONTROL) begin
            s_nxt.rd_data = {24'h000000, rc_view};
        end

        s_nxt.prefetch = {cmd_mem_en_in, cmd_mem_en_in};

        s_nxt.io_fwd = io_valid_in & io_window_hit_in & ~isa_block;

        // index at base, data at base+1
        s_nxt.index_hit = io_valid_in & (base_match | fixed_match) &
                          (pair_off == 2'h0);
        s_nxt.data_hit  = io_valid_in & (base_match | fixed_match) &
                          (pair_off == 2'h1);
        s_nxt.bad_hit   = io_valid_in & base_match &
                          (pair_off[1] == 1'b1);

        // Master abort handling, one-cycle verdicts
        s_nxt.ma_ones   = 1'b0;
        s_nxt.ma_drop   = 1'b0;
        s_nxt.ma_tabort = 1'b0;
        s_nxt.pci_serr  = 1'b0;
        if (ma_event_in) begin
            if (!s_r.ma_mode) begin
                s_nxt.ma_ones = ma_read_in;
                s_nxt.ma_drop = ~ma_read_in;
            end else if (!ma_read_in && ma_posted_in) begin
                s_nxt.pci_serr = cmd_serr_en_in;
                s_nxt.ma_drop  = 1'b1;
            end else begin
                s_nxt.ma_tabort = ma_origin_open_in;
                s_nxt.ma_drop   = ~ma_read_in & ~ma_origin_open_in;
            end
        end
        if (s_r.serr_fwd_en && !s_r.serr_sync) begin
            s_nxt.pci_serr = 1'b1;
        end

        s_nxt.perr_report = s_r.perr_resp_en & ~s_r.perr_sync;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Reset values all constants; pin stages idle high
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_r              <= '0;
            s_r.cb_reset     <= 1'(`BCR_BC_RESET >> `BCR_BC_CB_RESET);
            s_r.ma_mode      <= 1'(`BCR_BC_RESET >> `BCR_BC_MA_MODE);
            s_r.isa_en       <= 1'b0;
            s_r.serr_fwd_en  <= 1'b0;
            s_r.perr_resp_en <= 1'b0;
            s_r.pci_rty_en   <= 1'(`BCR_RC_RESET >> `BCR_RC_PCI_EN);
            s_r.cb_rty_en    <= 1'(`BCR_RC_RESET >> `BCR_RC_CB_EN);
            s_r.serr_meta    <= 1'b1;
            s_r.serr_sync    <= 1'b1;
            s_r.perr_meta    <= 1'b1;
            s_r.perr_sync    <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata_out        = s_r.rd_data;
    assign mem_prefetch_out     = s_r.prefetch;
    assign cb_reset_n_out       = ~s_r.cb_reset;
    assign ma_read_ones_out     = s_r.ma_ones;
    assign ma_write_drop_out    = s_r.ma_drop;
    assign ma_target_abort_out  = s_r.ma_tabort;
    assign io_forward_out       = s_r.io_fwd;
    assign legacy_index_hit_out = s_r.index_hit;
    assign legacy_data_hit_out  = s_r.data_hit;
    assign legacy_bad_hit_out   = s_r.bad_hit;
    assign pci_serr_out         = s_r.pci_serr;
    assign perr_report_out      = s_r.perr_report;

endmodule
`default_nettype wire

// [verification/bcr_regs_chk.sv]
// Port-level checks for the bridge control register bank.
// Assumes one clock domain and the port timing of bcr_regs.
`timescale 1ns/10ps
`default_nettype none

module bcr_regs_chk (
    input wire logic        clk_sys_in,
    input wire logic        reset_n_in,
    input wire logic [7:0]  reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic        cmd_mem_en_in,
    input wire logic [1:0]  mem_prefetch_out,
    input wire logic        cb_reset_n_out,
    input wire logic        ma_event_in,
    input wire logic        ma_read_in,
    input wire logic        ma_posted_in,
    input wire logic        ma_origin_open_in,
    input wire logic        ma_read_ones_out,
    input wire logic        ma_target_abort_out,
    input wire logic [31:0] io_addr_in,
    input wire logic        io_valid_in,
    input wire logic        io_window_hit_in,
    input wire logic        io_to_card_in,
    input wire logic        io_forward_out,
    input wire logic        cb_serr_n_in,
    input wire logic        pci_serr_out
);
    logic [6:0] bc_r;
    logic       blk;

    // ------------------------------------------------------------
    // Shadow of the writable bridge control bits
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            bc_r <= 7'h40;
        end else if (reg_wr_in && reg_addr_in == 8'h3e) begin
            bc_r <= reg_wdata_in[6:0];
        end
    end
    assign blk = bc_r[2] && io_to_card_in && io_addr_in[31:16] == 16'h0
                 && io_addr_in[9:8] != 2'h0;

    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);

    // Pin passes two sync flops and an output flop
    sequence serr_on;
        (!cb_serr_n_in && bc_r[1]) [*4];
    endsequence
    sequence serr_off;
        (!bc_r[1] && !ma_event_in) [*4];
    endsequence

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    bc_fixed_bits_a: assert property (
        reg_rd_in && reg_addr_in == 8'h3e
        |=> (reg_rdata_out & 32'hffff_ff98) == 32'h300)
        else $error("bridge control fixed bits wrong");
    legacy_low_bits_a: assert property (
        reg_rd_in && reg_addr_in == 8'h44 |=> reg_rdata_out[1:0] == 2'h1)
        else $error("legacy base low bits wrong");
    retry_rsvd_a: assert property (
        reg_rd_in && reg_addr_in == 8'h90
        |=> (reg_rdata_out & 32'hffff_ff30) == 32'h0)
        else $error("retry control reserved bits set");
    prefetch_gate_a: assert property (
        $past(reset_n_in) |-> mem_prefetch_out == {2{$past(cmd_mem_en_in)}})
        else $error("prefetch does not follow memory enable");
    card_reset_a: assert property (
        bc_r[6] == $past(bc_r[6]) |-> cb_reset_n_out == !bc_r[6])
        else $error("card reset pin disagrees with control bit");
    abort_ones_a: assert property (
        ma_event_in && ma_read_in && !bc_r[5]
        |=> ma_read_ones_out && !ma_target_abort_out)
        else $error("mode zero read abort not all ones");
    abort_target_a: assert property (
        ma_event_in && bc_r[5] && ma_origin_open_in
        && (ma_read_in || !ma_posted_in)
        |=> ma_target_abort_out && !ma_read_ones_out)
        else $error("mode one abort not target abort");
    isa_block_a: assert property (
        io_valid_in && io_window_hit_in |=> io_forward_out == !$past(blk))
        else $error("io forward wrong for alias block");
    serr_fwd_a: assert property (serr_on |-> pci_serr_out)
        else $error("card error not forwarded");
    serr_block_a: assert property (serr_off |-> !pci_serr_out)
        else $error("card error forwarded while disabled");
endmodule

bind bcr_regs bcr_regs_chk i_bcr_regs_chk (.*);

`default_nettype wire

// [verification/tb.sv]
// Self-checking bench for the bridge control register bank.
// Assumes bcr_regs with its checker bound; drives every port itself.
`timescale 1ns/10ps
`default_nettype none

`define CHK(n, e, g) check(n, 32'(e), 32'(g))

module tb;
    localparam logic [15:0] VEND = 16'h0f1e; // Arbitrary value
    localparam logic [15:0] SUBC = 16'h2d3c; // Arbitrary value
    logic        clk_sys_in, reset_n_in, reg_wr_in, reg_rd_in;
    logic [7:0]  reg_addr_in;
    logic [31:0] reg_wdata_in, reg_rdata_out, io_addr_in;
    logic        cmd_mem_en_in, cmd_serr_en_in, cb_reset_n_out;
    logic [1:0]  mem_prefetch_out;
    logic        ma_event_in, ma_read_in, ma_posted_in, ma_origin_open_in;
    logic        ma_read_ones_out, ma_write_drop_out, ma_target_abort_out;
    logic        io_valid_in, io_window_hit_in, io_to_card_in;
    logic        io_forward_out, legacy_index_hit_out, legacy_data_hit_out;
    logic        legacy_bad_hit_out, cb_serr_n_in, cb_perr_n_in;
    logic        pci_serr_out, perr_report_out, blk, rel, mt;
    logic [3:0]  retry_active_in, ex;
    logic [7:0]  regs [6] = '{8'h3e, 8'h40, 8'h42, 8'h44, 8'h90, 8'h80};
    logic [31:0] ioa [9] = '{32'h3e0, 32'h3e1, 32'h3e2, 32'h12000,
                             32'h12001, 32'h12002, 32'h1100, 32'h1000,
                             32'h11300};
    int          fails, comparisons, bc, base, rc;

    bcr_regs #(.SUBSYS_VENDOR(VEND), .SUBSYS_CODE(SUBC), .RETRY_LIMIT(4))
        i_bcr_regs (.*);

    initial begin
        clk_sys_in = 1'b0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end

    task automatic check(string n, logic [31:0] e, logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Register port and model
    // ------------------------------------------------------------
    function automatic logic [31:0] expv(logic [7:0] a);
        case (a)
            8'h3e: return 32'h300 | bc;
            8'h40: return {16'h0, VEND};
            8'h42: return {16'h0, SUBC};
            8'h44: return {base[19:0], 12'h001};
            8'h90: return 32'(rc);
            default: return 32'h0;
        endcase
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        cmd_mem_en_in <= 1'($urandom);
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
        case (a)
            8'h3e: bc = d & 32'h67;
            8'h44: base = d[31:12];
            8'h90: rc = (d & 32'hc0) | (rc & 32'hf & ~d[3:0]);
            default: ;
        endcase
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        @(negedge clk_sys_in);
        `CHK("rdata", expv(a), reg_rdata_out);
        `CHK("prefetch", {2{cmd_mem_en_in}}, mem_prefetch_out);
    endtask

    initial begin
        #(20 * 20000);
        fails++;
        summarize();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        {reset_n_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
        {cmd_mem_en_in, cmd_serr_en_in, ma_event_in, ma_read_in} = '0;
        {ma_posted_in, ma_origin_open_in, io_addr_in, io_valid_in} = '0;
        {io_window_hit_in, io_to_card_in, retry_active_in} = '0;
        {cb_serr_n_in, cb_perr_n_in} = 2'h3;
        {bc, base, rc} = {32'h40, 32'h0, 32'h0};
        void'($urandom(51304));
        repeat (4) @(posedge clk_sys_in);
        `CHK("card_rst", 1'b0, cb_reset_n_out);
        reset_n_in <= 1'b1;
        foreach (regs[k]) rd(regs[k]);
        $display("test reset done");
        repeat (6) foreach (regs[k]) begin
            wr(regs[k], $urandom);
            rd(regs[k]);
            `CHK("card_rst", !bc[6], cb_reset_n_out);
        end
        $display("test random done");
        for (int i = 0; i < 32; i++) begin
            wr(8'h3e, (bc & ~32'h20) | (i[4] << 5));
            @(posedge clk_sys_in);
            ma_event_in <= 1'b1;
            {cmd_serr_en_in, ma_read_in, ma_posted_in} <= i[3:1];
            ma_origin_open_in <= i[0];
            @(posedge clk_sys_in);
            ma_event_in <= 1'b0;
            @(negedge clk_sys_in);
            if (!i[4]) ex = {i[2], !i[2], 2'b00};
            else if (!i[2] && i[1]) ex = {3'b010, i[3]};
            else if (i[0]) ex = 4'b0010;
            else ex = {1'b0, !i[2], 2'b00};
            `CHK("abort", ex, {ma_read_ones_out, ma_write_drop_out,
                 ma_target_abort_out, pci_serr_out});
        end
        $display("test abort done");
        wr(8'h44, 32'h0001_2000);
        for (int k = 0; k < 2; k++) begin
            wr(8'h3e, (bc & ~32'h4) | (k << 2));
            foreach (ioa[j]) begin
                @(posedge clk_sys_in);
                {io_valid_in, io_addr_in} <= {1'b1, ioa[j]};
                io_to_card_in <= 1'($urandom);
                io_window_hit_in <= 1'($urandom);
                @(posedge clk_sys_in);
                io_valid_in <= 1'b0;
                @(negedge clk_sys_in);
                blk = k[0] && io_to_card_in && ioa[j][31:16] == 16'h0
                      && ioa[j][9:8] != 2'h0;
                rel = ioa[j][31:12] == base[19:0] && ioa[j][11:2] == 10'h0;
                mt = rel || ioa[j][31:2] == 30'h0f8;
                `CHK("io_fwd", io_window_hit_in && !blk, io_forward_out);
                `CHK("legacy", {mt && ioa[j][1:0] == 2'h0,
                     mt && ioa[j][1:0] == 2'h1, rel && ioa[j][1]},
                     {legacy_index_hit_out, legacy_data_hit_out,
                      legacy_bad_hit_out});
            end
        end
        $display("test io done");
        for (int k = 0; k < 2; k++) begin
            wr(8'h3e, (bc & ~32'h3) | (k[0] ? 32'h3 : 32'h0));
            @(posedge clk_sys_in);
            {cb_serr_n_in, cb_perr_n_in} <= 2'h0;
            repeat (4) @(posedge clk_sys_in);
            @(negedge clk_sys_in);
            `CHK("card_err", {2{k[0]}}, {pci_serr_out, perr_report_out});
            @(posedge clk_sys_in);
            {cb_serr_n_in, cb_perr_n_in} <= 2'h3;
            repeat (4) @(posedge clk_sys_in);
        end
        $display("test pins done");
        for (int en = 0; en < 2; en++) begin
            wr(8'h90, en[0] ? 32'hc0 : 32'h0);
            for (int b = 0; b < 4; b++) begin
                @(posedge clk_sys_in);
                retry_active_in <= 4'(1 << b);
                repeat (10) @(posedge clk_sys_in);
                retry_active_in <= 4'h0;
                rc = rc | (en << b);
                rd(8'h90);
            end
        end
        wr(8'h90, 32'hc5);
        rd(8'h90);
        $display("test retry done");
        summarize();
    end
endmodule

`default_nettype wire
